// File: bench/tb_wit_top.sv
/* Bench for wit_top: register port, taps, periods, stops.
 Assumes the subsystem tick pulses every second clock, or every clock in t_watch. */
`timescale 1ns/1ps
module tb_wit_top;
   logic        clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, sub_tick_i = 0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0]  wdata_i = 8'h00, wmask_i = 8'h00, rdata_o;
   logic        watch_irq_o, interval_irq_o;
   int          n_fail = 0, checked = 0, n, a, b;
   bit          fast = 1'b0;
   wit_top u_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wmask_i, .wr_i, .rd_i, .rdata_o,
      .sub_tick_i, .watch_irq_o, .interval_irq_o);
   initial forever #12.5 clk_i = ~clk_i;
   // Tick on every clock in t_watch keeps the long periods inside the run budget
   always @(posedge clk_i) sub_tick_i <= fast | ~sub_tick_i;
   task close_out;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [15:0] ad, input logic [7:0] d, input logic [7:0] m);
      @(posedge clk_i);
      {addr_i, wdata_i, wmask_i, wr_i} <= {ad, d, m, 1'b1};
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] ad, input logic [7:0] e);
      @(posedge clk_i);
      {addr_i, rd_i} <= {ad, 1'b1};
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask : rd
   task wt(input bit w);
      n = 0;
      while (n == 0 || (!(w ? watch_irq_o : interval_irq_o) && n < 40000))
      begin
         @(posedge clk_i);
         #1 n++;
      end
      if (n >= 40000)
      begin
         n_fail++;
         close_out();
      end
   endtask : wt
   task gap(input bit w, input int e);
      wt(w);
      wt(w);
      chk(n, e);
   endtask : gap
   task quiet;
      {a, b} = 0;
      repeat (100)
      begin
         @(posedge clk_i);
         #1 a += watch_irq_o;
         b += interval_irq_o;
      end
   endtask : quiet
   task t_regs;
      rd(16'hFF6F, 8'h00);
      wr(16'hFF6F, 8'h5A, 8'hFF);
      rd(16'hFF6F, 8'h5A);
      wr(16'hFF6F, 8'h00, 8'h02);
      rd(16'hFF6F, 8'h58);
      wr(16'h1234, 8'hFF, 8'hFF);
      rd(16'hFF6F, 8'h58);
      rd(16'h1234, 8'h00);
      $display("t_regs end");
   endtask : t_regs
   task t_intv;
      for (int i = 0; i < 8; i++)
      begin
         wr(16'hFF6F, 8'h00, 8'hFF);
         wr(16'hFF6F, 8'h81 | 8'(i << 4), 8'hFF);
         gap(0, 2 << (i + 4));
      end
      wr(16'hFF6F, 8'h00, 8'hFF);
      wr(16'hFF6F, 8'h01, 8'hFF);
      gap(0, 2048);
      $display("t_intv end");
   endtask : t_intv
   task t_watch;
      fast = 1'b1;
      for (int p = 3; p >= 0; p--)
      begin
         wr(16'hFF6F, 8'h00, 8'hFF);
         wr(16'hFF6F, 8'h83 | 8'(p << 2), 8'hFF);
         gap(1, p == 3 ? 16 : p == 2 ? 32 : p == 1 ? 8192 : 16384);
      end
      // Run cleared after 7 of 16 steps; prescaler phase kept, so 7 + 16 steps lie between the irqs
      wr(16'hFF6F, 8'h00, 8'hFF);
      wr(16'hFF6F, 8'h87, 8'hFF);
      wt(1);
      repeat (4000) @(posedge clk_i);
      wr(16'hFF6F, 8'h00, 8'h02);
      wr(16'hFF6F, 8'h02, 8'h02);
      wt(1);
      chk(4004 + n, 23 * 512);
      fast = 1'b0;
      $display("t_watch end");
   endtask : t_watch
   task t_stop;
      wr(16'hFF6F, 8'h00, 8'hFF);
      wr(16'hFF6F, 8'h8F, 8'hFF);
      wt(1);
      wr(16'hFF6F, 8'h00, 8'h02);
      quiet();
      chk(a, 0);
      chk(b, 3);
      wr(16'hFF6F, 8'h02, 8'h02);
      gap(1, 32);
      wr(16'hFF6F, 8'h00, 8'h01);
      quiet();
      chk(a + b, 0);
      $display("t_stop end");
   endtask : t_stop
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_intv();
      t_watch();
      t_stop();
      close_out();
   end
endmodule : tb_wit_top

// File: bench/wit_top_assertions.sv
/* Port checker for wit_top, bound to the top.
 Assumes one clock and a sync active-low reset. */
`timescale 1ns/1ps
module wit_top_chk
(
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0]  wdata_i,
   input wire logic [7:0]  wmask_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [7:0]  rdata_o,
   input wire logic        sub_tick_i,
   input wire logic        watch_irq_o,
   input wire logic        interval_irq_o
);
   logic [7:0] m_q;
   logic       hit;
   assign hit = addr_i == 16'hFF6F;
   // Shadow of the mode register
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         m_q <= 8'h00;
      else if (wr_i && hit)
         m_q <= (m_q & ~wmask_i) | (wdata_i & wmask_i);
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_watch_one_cycle: assert property (watch_irq_o |=> !watch_irq_o)
      else $error("watch irq wide");
   chk_intv_one_cycle: assert property (interval_irq_o |=> !interval_irq_o)
      else $error("interval irq wide");
   chk_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("rdata not idle");
   chk_read_miss_zero: assert property (rd_i && !hit |=> rdata_o == 8'h00)
      else $error("unmapped read");
   chk_read_mode_value: assert property (rd_i && hit |=> rdata_o == $past(m_q))
      else $error("mode readback");
   chk_stop_quiet: assert property (!m_q[0] [*3] |-> !interval_irq_o && !watch_irq_o)
      else $error("irq while stopped");
   chk_run_gate: assert property (!m_q[1] [*3] |-> !watch_irq_o)
      else $error("watch irq without run");
   chk_sub_tick_cause: assert property (m_q[7] && interval_irq_o |-> $past(sub_tick_i) || $past(sub_tick_i, 2))
      else $error("irq without tick");
endmodule : wit_top_chk

bind wit_top wit_top_chk u_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wmask_i, .wr_i, .rd_i, .rdata_o,
   .sub_tick_i, .watch_irq_o, .interval_irq_o);

// File: core/wit_defs.svh
/*
 Constants for the watch interval timer: register offset, field positions,
 reset value, divider and tap figures.
 Assumes a single 40 MHz system clock and the plain register port of the top.
*/
// Functional notes
// - The clock select bit picks main clock divided by 128 when 0 and the subsystem clock when 1 as the watch clock.
// - The 3-bit tap field in bits 4 to 6 sets the interval period from 2^4 to 2^11 watch clocks, doubling per code.
// - The 2-bit period field in bits 2 and 3 sets the watch period to 2^14, 2^13, 2^5 or 2^4 watch clocks.
// - Setting the counter run bit starts the 5-bit counter, and clearing it stops and clears that counter.
// - The global enable bit allows operation when 1, and when 0 stops and clears both prescaler and counter.
// - The watch function counts only while both enable and run bits are 1, else the counter clears and no watch irq.
// - Clearing only the run bit restarts the watch count from zero without clearing the prescaler.
// - The interval irq repeats at the tap period while global enable is 1, whatever the run bit.
// - The first watch irq may come early by the prescaler phase, later ones come exactly at the period.
// - Reset clears the 8-bit mode register to zero, and it accepts whole-byte and single-bit writes.
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH

`define WIT_ADDR_MODE      16'hFF6F
`define WIT_ADDR_W         16
`define WIT_MODE_RESET     8'h00
`define WIT_BIT_ENABLE     0
`define WIT_BIT_RUN        1
`define WIT_BIT_PER_LO     2
`define WIT_BIT_PER_HI     3
`define WIT_BIT_TAP_LO     4
`define WIT_BIT_TAP_HI     6
`define WIT_BIT_CLKSEL     7
`define WIT_MAIN_DIV_W     7
`define WIT_MAIN_DIV_MAX   7'h7F
`define WIT_PRE_W          11
`define WIT_CNT_W          5
`define WIT_CNT_MAX        5'h1F
`define WIT_TAP_BASE       4
`define WIT_CNT_TAP        9
`define WIT_PER_LONG_SLOW  2'h0
`define WIT_PER_LONG_FAST  2'h1
`define WIT_PER_SHORT_5    2'h2
`define WIT_PER_SHORT_4    2'h3
`define WIT_CNT_HALF       5'h0F

`endif

// File: core/wit_pkg.sv
/*
 Types for the watch interval timer.
 Assumes wit_defs.svh is included by the users.
*/
package wit_pkg;
   typedef logic [7:0]  wit_byte_t;
   typedef logic [10:0] wit_pre_t;
   typedef logic [4:0]  wit_cnt_t;
endpackage : wit_pkg

// File: core/wit_prescaler.sv
/*
 Watch clock source selection and 11-bit prescaler with tap strobes.
 Assumes a subsystem clock tick input already synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "wit_defs.svh"
module wit_prescaler
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              clk_sel_i,
   input  wire logic              sub_tick_i,
   input  wire logic              enable_i,
   output wire logic              wclk_tick_o,
   output wit_pkg::wit_pre_t      pre_rise_o
);
   logic [`WIT_MAIN_DIV_W-1:0] div_q;
   wit_pkg::wit_pre_t          pre_q;
   wit_pkg::wit_pre_t          pre_d;
   logic                       main_tick;
   logic                       tick;

   assign main_tick = (div_q == `WIT_MAIN_DIV_MAX);
   assign tick      = enable_i & (clk_sel_i ? sub_tick_i : main_tick);
   assign pre_d     = pre_q + 11'h001;

   // Main clock divide by 128 runs free so the phase is not tied to enable
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         div_q <= '0;
      else
         div_q <= div_q + 7'h01;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || !enable_i)
         pre_q <= '0;
      else if (tick)
         pre_q <= pre_d;
   end

   // One-cycle strobe per bit going 0 to 1; bit k rises once per 2^(k+1) ticks
   assign pre_rise_o  = tick ? (pre_d & ~pre_q) : '0;
   assign wclk_tick_o = tick;
endmodule : wit_prescaler

// File: core/wit_top.sv
/*
 Watch interval timer: mode register, 5-bit watch counter and two irq pulses.
 Assumes a register port with read data one cycle after the read strobe, and
 a subsystem clock tick pulse synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "wit_defs.svh"
module wit_top
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   input  wire logic [`WIT_ADDR_W-1:0]  addr_i,
   input  wire logic [7:0]              wdata_i,
   input  wire logic [7:0]              wmask_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   output logic      [7:0]              rdata_o,
   input  wire logic                    sub_tick_i,
   output logic                         watch_irq_o,
   output logic                         interval_irq_o
);
   wit_pkg::wit_byte_t  watch_mode_control_q;
   wit_pkg::wit_cnt_t   cnt_q;
   wit_pkg::wit_pre_t   pre_rise;
   logic                wclk_tick;
   logic                global_enable;
   logic                counter_run;
   logic                watch_on;
   logic                cnt_step;
   logic                watch_hit;
   logic                interval_hit;
   logic [1:0]          watch_period;
   logic [2:0]          interval_tap;

   function automatic logic tap_rise(input wit_pkg::wit_pre_t r, input int unsigned pow);
      // Bit pow-1 rises once every 2^pow watch clocks
      tap_rise = r[pow-1];
   endfunction : tap_rise

   assign global_enable = watch_mode_control_q[`WIT_BIT_ENABLE];
   assign counter_run   = watch_mode_control_q[`WIT_BIT_RUN];
   assign watch_period  = watch_mode_control_q[`WIT_BIT_PER_HI:`WIT_BIT_PER_LO];
   assign interval_tap  = watch_mode_control_q[`WIT_BIT_TAP_HI:`WIT_BIT_TAP_LO];
   assign watch_on      = global_enable & counter_run;

   // Byte write uses a full mask, a bit set or clear uses a single-bit mask
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         watch_mode_control_q <= `WIT_MODE_RESET;
      else if (wr_i && addr_i == `WIT_ADDR_MODE)
         watch_mode_control_q <= (watch_mode_control_q & ~wmask_i) | (wdata_i & wmask_i);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         rdata_o <= '0;
      else if (rd_i && addr_i == `WIT_ADDR_MODE)
         rdata_o <= watch_mode_control_q;
      else
         rdata_o <= '0;
   end

   wit_prescaler u_pre
   (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .clk_sel_i   (watch_mode_control_q[`WIT_BIT_CLKSEL]),
      .sub_tick_i  (sub_tick_i),
      .enable_i    (global_enable),
      .wclk_tick_o (wclk_tick),
      .pre_rise_o  (pre_rise)
   );

   // Long periods step on the 2^9 tap, short ones on each watch clock
   always_comb
   begin
      if (watch_period == `WIT_PER_LONG_SLOW || watch_period == `WIT_PER_LONG_FAST)
         cnt_step = tap_rise(pre_rise, `WIT_CNT_TAP);
      else
         cnt_step = wclk_tick;
   end

   // Prescaler is not cleared by run alone, so the first long period can slip
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || !watch_on)
         cnt_q <= '0;
      else if (cnt_step)
         cnt_q <= cnt_q + 5'h01;
   end

   always_comb
   begin
      case (watch_period)
         `WIT_PER_LONG_SLOW: watch_hit = cnt_step && cnt_q == `WIT_CNT_MAX;
         `WIT_PER_LONG_FAST: watch_hit = cnt_step && {1'b0, cnt_q[3:0]} == `WIT_CNT_HALF;
         `WIT_PER_SHORT_5:   watch_hit = tap_rise(pre_rise, `WIT_TAP_BASE + 1);
         default:            watch_hit = tap_rise(pre_rise, `WIT_TAP_BASE);
      endcase
   end

   // Tap changes while running are the caller's burden; no resync is done
   assign interval_hit = pre_rise[`WIT_TAP_BASE - 1 + interval_tap];

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         watch_irq_o <= 1'b0;
      else
         watch_irq_o <= watch_on & watch_hit;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         interval_irq_o <= 1'b0;
      else
         interval_irq_o <= global_enable & interval_hit;
   end
endmodule : wit_top
